//--- rtl/eep_pkg.sv
// Shared constants and types for the serial EEPROM pin front end
package eep_pkg;

	// ==========================================================
	// Array geometry
	localparam int          EEP_MEM_DEPTH = 262144;   // Byte locations
	localparam int          EEP_DATA_W    = 8;        // Bits per location
	localparam int          EEP_ADDR_W    = 18;       // Address pointer width
	localparam logic [17:0] EEP_PTR_RST   = 18'h00000;

	// ==========================================================
	// Select byte layout: type code, select bit, high address, direction
	localparam logic [3:0]  EEP_TYPE_CODE = 4'ha;
	localparam int          EEP_SEL_TYPE_HI = 7;
	localparam int          EEP_SEL_TYPE_LO = 4;
	localparam int          EEP_SEL_ASEL  = 3;
	localparam int          EEP_SEL_A_HI  = 2;
	localparam int          EEP_SEL_A_LO  = 1;
	localparam int          EEP_SEL_RW    = 0;

	// ==========================================================
	// Bit counter landmarks within one byte frame
	localparam logic [3:0]  EEP_CNT_RST   = 4'h0;
	localparam logic [3:0]  EEP_CNT_ACK   = 4'h8;     // Ninth clock is the acknowledge
	localparam logic [3:0]  EEP_CNT_DONE  = 4'h9;

	// ==========================================================
	// Synchronised pin bundle
	typedef struct packed {
		logic scl;
		logic sda;
		logic addr_sel;
		logic wp_pin;
	} eep_pins_t;

	localparam eep_pins_t   EEP_PINS_RST  = '{scl: 1'b1, sda: 1'b1, addr_sel: 1'b0, wp_pin: 1'b0};

	// ==========================================================
	// Transaction states
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_DEVSEL  = 6'h02,
		ST_ADDR_HI = 6'h04,
		ST_ADDR_LO = 6'h08,
		ST_WRITE   = 6'h10,
		ST_READ    = 6'h20
	} eep_state_t;

endpackage

//--- rtl/eep_client.sv
// Two-wire serial EEPROM client: pin sampling, select match, byte array
// ==========================================================
// What this block does
// - Answer only when select byte address bit equals the address-select input
// - Address-select and write-protect sync flops reset low; after reset they follow the pins as sampled
// - Take command and write-data bits from SDA on SCL rising edge
// - Change outgoing read bit only after an SCL falling edge
// - SDA is open-drain: pull low or release, never drive high
// - Write-protect high refuses every array write; low lets writes proceed
// - Storage of 262,144 locations of one 8-bit byte each
`timescale 1ns/1ps

module eep_client import eep_pkg::*; #(
	parameter int MEM_DEPTH = EEP_MEM_DEPTH,
	parameter int ADDR_W    = EEP_ADDR_W
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// Two-wire bus
	input  wire logic scl_in,
	input  wire logic sda_in,
	output wire logic sda_out,
	output      logic sda_oe,
	// Strap pins
	input  wire logic address_select_input,
	input  wire logic write_protect
);

	// ==========================================================
	// Declarations
	eep_pins_t             pins_raw;
	eep_pins_t             pins_s1;
	eep_pins_t             pins_s2;
	eep_pins_t             pins_s3;
	eep_state_t            state;
	logic [3:0]            bit_cnt;
	logic [7:0]            shreg;
	logic [7:0]            rd_byte;
	logic [ADDR_W-1:0]     ptr;
	logic                  ack_mine;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  bus_start;
	logic                  bus_stop;
	logic                  byte_end;
	logic                  sel_match;
	logic                  mem_we;
	logic [EEP_DATA_W-1:0] mem [MEM_DEPTH];

	// ==========================================================
	// Pin sampling
	assign pins_raw = '{scl: scl_in, sda: sda_in, addr_sel: address_select_input,
		wp_pin: write_protect};

	// Three flops per pin; straps reset low, then follow the pin, so a floating pin is not forced low
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pins_s1 <= EEP_PINS_RST;
			pins_s2 <= EEP_PINS_RST;
			pins_s3 <= EEP_PINS_RST;
		end else begin
			pins_s1 <= pins_raw;
			pins_s2 <= pins_s1;
			pins_s3 <= pins_s2;
		end
	end

	// Edge and condition detect on the second and third stages
	assign scl_rise  = pins_s2.scl & ~pins_s3.scl;
	assign scl_fall  = ~pins_s2.scl & pins_s3.scl;
	// Start and stop rely on SCL resting high between frames
	assign bus_start = pins_s2.scl & pins_s3.scl & pins_s3.sda & ~pins_s2.sda;
	assign bus_stop  = pins_s2.scl & pins_s3.scl & ~pins_s3.sda & pins_s2.sda;
	assign byte_end  = scl_fall && (bit_cnt == EEP_CNT_ACK);

	// Select byte: type code plus the hard-wired select bit
	assign sel_match = (shreg[EEP_SEL_TYPE_HI:EEP_SEL_TYPE_LO] == EEP_TYPE_CODE)
		&& (shreg[EEP_SEL_ASEL] == pins_s2.addr_sel);

	// Array write only while unprotected
	assign mem_we = byte_end && (state == ST_WRITE) && !pins_s2.wp_pin;

	// Open drain: the data level is always low, only the enable moves
	assign sda_out = 1'b0;

	// ==========================================================
	// Bit counter and input shift register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt <= EEP_CNT_RST;
			shreg   <= 8'h00;
		end else if (bus_start || bus_stop) begin
			bit_cnt <= EEP_CNT_RST;
		end else if (state != ST_IDLE) begin
			if (scl_rise && bit_cnt != EEP_CNT_DONE) begin
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt < EEP_CNT_ACK && state != ST_READ) begin
					shreg <= {shreg[6:0], pins_s2.sda};
				end
			end else if (scl_fall && bit_cnt == EEP_CNT_DONE) begin
				bit_cnt <= EEP_CNT_RST;
			end
		end
	end

	// ==========================================================
	// Transaction state, pointer and acknowledge ownership
	// Ack checks sit at the end of the byte so the host sees them in the ninth clock
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state    <= ST_IDLE;
			ptr      <= EEP_PTR_RST;
			ack_mine <= 1'b0;
		end else if (bus_start) begin
			state    <= ST_DEVSEL;
			ack_mine <= 1'b0;
		end else if (bus_stop) begin
			state    <= ST_IDLE;
			ack_mine <= 1'b0;
		end else if (byte_end) begin
			ack_mine <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					state <= ST_IDLE;
				end
				ST_DEVSEL: begin
					if (sel_match) begin
						ack_mine <= 1'b1;
						if (shreg[EEP_SEL_RW]) begin
							state <= ST_READ;
						end else begin
							state <= ST_ADDR_HI;
							ptr[ADDR_W-1:ADDR_W-2] <= shreg[EEP_SEL_A_HI:EEP_SEL_A_LO];
						end
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_ADDR_HI: begin
					ack_mine   <= 1'b1;
					ptr[15:8]  <= shreg;
					state      <= ST_ADDR_LO;
				end
				ST_ADDR_LO: begin
					ack_mine   <= 1'b1;
					ptr[7:0]   <= shreg;
					state      <= ST_WRITE;
				end
				ST_WRITE: begin
					// Protected data bytes are not acknowledged
					if (!pins_s2.wp_pin) begin
						ack_mine <= 1'b1;
						ptr[7:0] <= ptr[7:0] + 8'h01; // Page wrap within 256 bytes
					end
				end
				ST_READ: begin
					ptr <= ptr + {{(ADDR_W-1){1'b0}}, 1'b1}; // Full array roll-over
				end
			endcase
		end else if (scl_rise && bit_cnt == EEP_CNT_ACK && state == ST_READ && !ack_mine
			&& pins_s2.sda) begin
			state <= ST_IDLE; // Host declined more data
		end
	end

	// ==========================================================
	// Byte array
	// No reset: a large array is left as storage, not control state
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[ptr] <= shreg;
		end
	end

	// ==========================================================
	// Output byte and SDA enable, changed only after SCL falls
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sda_oe  <= 1'b0;
			rd_byte <= 8'h00;
		end else if (bus_start || bus_stop) begin
			sda_oe  <= 1'b0;
		end else if (scl_fall) begin
			if (byte_end) begin
				// Ack for own slot; released in read so host can answer
				sda_oe <= (state == ST_DEVSEL) ? sel_match
					: (state == ST_ADDR_HI || state == ST_ADDR_LO) ? 1'b1
					: (state == ST_WRITE) ? !pins_s2.wp_pin : 1'b0;
			end else if (bit_cnt == EEP_CNT_DONE && state == ST_READ) begin
				rd_byte <= mem[ptr];
				sda_oe  <= ~mem[ptr][7];
			end else if (bit_cnt == EEP_CNT_DONE) begin
				sda_oe  <= 1'b0;
			end else if (state == ST_READ && bit_cnt != EEP_CNT_RST) begin
				sda_oe  <= ~rd_byte[3'(4'h7 - bit_cnt)];
			end
		end
	end

	// ==========================================================
	// Checks
	chk_oe_fall_only: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(sda_oe) |-> $past(scl_fall))
		else $error("SDA pulled low outside an SCL falling edge");

	// Line must be free in the host's acknowledge slot of a read byte
	chk_ack_release: assert property (@(posedge sys_clk) disable iff (!nrst)
		(byte_end && state == ST_READ) |=> !sda_oe)
		else $error("SDA held low in host acknowledge slot");

	chk_wp_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
		(byte_end && state == ST_WRITE && pins_s2.wp_pin) |=> !sda_oe)
		else $error("Protected write byte acknowledged");

	// Held against the pin itself, two flops back, so a broken sync path shows
	chk_wp_no_store: assert property (@(posedge sys_clk) disable iff (!nrst)
		mem_we |-> !$past(write_protect, 2))
		else $error("Array written while protected");

	chk_sel_mismatch: assert property (@(posedge sys_clk) disable iff (!nrst)
		(byte_end && state == ST_DEVSEL && shreg[EEP_SEL_ASEL] != pins_s2.addr_sel)
		|=> (state == ST_IDLE) && !sda_oe)
		else $error("Select byte with wrong address bit answered");

	chk_shift_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
		(scl_rise && bit_cnt < EEP_CNT_ACK && !bus_start && !bus_stop
		&& (state == ST_DEVSEL || state == ST_WRITE)) |=> shreg[0] == $past(pins_s2.sda))
		else $error("Bit not captured on SCL rise");

	chk_ptr_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		(byte_end && state == ST_READ) |=> ptr == $past(ptr) + 18'h00001)
		else $error("Read pointer did not advance");

	chk_mem_store: assert property (@(posedge sys_clk) disable iff (!nrst)
		mem_we |=> mem[$past(ptr)] == $past(shreg))
		else $error("Write byte not stored");

	chk_strap_sync: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(pins_s2.addr_sel) |-> $past(address_select_input, 2))
		else $error("Address select seen high without a high pin");

endmodule

//--- tb/eep_host.sv
// Two-wire bus host model for the serial EEPROM client
`timescale 1ns/1ps

module eep_host (
	// System clock for pacing
	input  wire logic sys_clk,
	// Bus
	input  wire logic sda_oe,
	output logic      scl,
	output wire logic sda
);
	logic host_low = 1'b0;
	// Pull-up wins unless someone pulls low; nobody drives high
	assign sda = ~(host_low | sda_oe);
	// Clock stands high between frames
	initial scl = 1'b1;

	// ==========================================================
	// Quarter of the 160 ns bus period, stepped on falling edges
	task automatic q;
		repeat (8) @(negedge sys_clk);
	endtask

	// Data set while clock low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic seen);
		host_low = ~b;
		q();
		scl = 1'b1;
		q();
		q();
		seen = sda;
		scl = 1'b0;
		q();
	endtask

	// Start or repeated start
	task automatic start;
		host_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		host_low = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask

	// Stop, then the bus is left idle with both lines high
	task automatic stop;
		host_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		host_low = 1'b0;
		q();
	endtask

	// One byte MSB first plus the ninth acknowledge clock
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule

//--- tb/eep_client_tb_top.sv
// Self-checking bench for the serial EEPROM client
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", what, exp, got); end end

module eep_client_tb_top import eep_pkg::*; ;
	logic       sys_clk = 1'b0;
	logic       nrst    = 1'b0;
	logic       addr_sel = 1'b0;
	logic       wp      = 1'b0;
	logic       scl;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic       prev_oe = 1'b0;
	logic [7:0] rx;
	logic       ack;
	int         failures = 0;
	int         n_tests  = 0;

	always #2.5 sys_clk = ~sys_clk;

	eep_client i_dut (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .address_select_input(addr_sel),
		.write_protect(wp));
	eep_host i_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	// Pin watch: output only ever low, moves only while clock is low
	always @(posedge sys_clk) begin
		if (sda_oe === 1'b1) `CHK("sda_out", 1'b0, sda_out)
		if (nrst && sda_oe !== prev_oe) `CHK("scl at sda move", 1'b0, scl)
		prev_oe <= sda_oe;
	end

	// ==========================================================
	// Shared bus sequences
	task automatic sel(input logic a, input logic [1:0] hi, input logic rw);
		i_host.xfer({EEP_TYPE_CODE, a, hi, rw}, 1'b1, rx, ack);
	endtask

	task automatic set_ptr(input logic [17:0] addr);
		i_host.start();
		sel(1'b0, addr[17:16], 1'b0);
		`CHK("select ack", 1'b0, ack)
		i_host.xfer(addr[15:8], 1'b1, rx, ack);
		i_host.xfer(addr[7:0], 1'b1, rx, ack);
	endtask

	task automatic wr(input logic [17:0] addr, input logic [7:0] d, input logic exp_ack);
		set_ptr(addr);
		i_host.xfer(d, 1'b1, rx, ack);
		`CHK("data ack", exp_ack, ack)
		i_host.stop();
	endtask

	// Random read start, then bytes until the host declines
	task automatic rd_begin(input logic [17:0] addr);
		set_ptr(addr);
		i_host.start();
		sel(1'b0, 2'b00, 1'b1);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_rw;
		wr(18'h3abfe, 8'h5a, 1'b0);
		wr(18'h3abff, 8'ha5, 1'b0);
		wr(18'h0abfe, 8'h0f, 1'b0);
		rd_begin(18'h3abfe);
		i_host.xfer(8'hff, 1'b0, rx, ack);
		`CHK("read 3abfe", 8'h5a, rx)
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("read 3abff", 8'ha5, rx)
		i_host.stop();
		rd_begin(18'h0abfe);
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("read 0abfe", 8'h0f, rx)
		i_host.stop();
		$display("t_rw done");
	endtask

	task automatic t_select;
		addr_sel = 1'b1;
		i_host.start();
		sel(1'b0, 2'b00, 1'b0);
		`CHK("strap 1 sel 0", 1'b1, ack)
		i_host.stop();
		i_host.start();
		sel(1'b1, 2'b00, 1'b0);
		`CHK("strap 1 sel 1", 1'b0, ack)
		i_host.stop();
		// Undriven strap is modelled by the pad pull-down level
		addr_sel = 1'b0;
		i_host.start();
		sel(1'b1, 2'b00, 1'b0);
		`CHK("strap float sel 1", 1'b1, ack)
		i_host.stop();
		$display("t_select done");
	endtask

	task automatic t_protect;
		wp = 1'b1;
		wr(18'h3abfe, 8'hc3, 1'b1);
		wp = 1'b0;
		rd_begin(18'h3abfe);
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("kept 3abfe", 8'h5a, rx)
		i_host.stop();
		$display("t_protect done");
	endtask

	// Page wrap on write, read from 1c2ff on into 1c300 and current-address read on the read side
	task automatic t_page;
		set_ptr(18'h1c2ff);
		i_host.xfer(8'h3c, 1'b1, rx, ack);
		`CHK("page ack 1", 1'b0, ack)
		i_host.xfer(8'hc3, 1'b1, rx, ack);
		`CHK("page ack 2", 1'b0, ack)
		i_host.stop();
		wr(18'h1c300, 8'h96, 1'b0);
		rd_begin(18'h1c200);
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("page wrap 1c200", 8'hc3, rx)
		i_host.stop();
		rd_begin(18'h1c2ff);
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("read 1c2ff", 8'h3c, rx)
		i_host.stop();
		i_host.start();
		sel(1'b0, 2'b00, 1'b1);
		`CHK("current read ack", 1'b0, ack)
		i_host.xfer(8'hff, 1'b1, rx, ack);
		`CHK("roll to 1c300", 8'h96, rx)
		i_host.stop();
		$display("t_page done");
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog: the run needs about 86 us, well under the 300 us limit
	initial begin
		#300000;
		failures++;
		give_verdict();
	end

	initial begin
		repeat (5) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_rw();
		t_select();
		t_protect();
		t_page();
		give_verdict();
	end
endmodule
